// file: adp_pkg.sv
package adp_pkg;

	// ==========================================================
	// output behaviour of a port while it writes
	typedef enum logic [1:0] {
		adp_read_first,
		adp_write_first,
		adp_hold
	} adp_mode_t;

	// ==========================================================
	// register offsets (byte addresses, one 32-bit word each)
	localparam logic [3:0] ADP_CTRL_OFS   = 4'h0;
	localparam logic [3:0] ADP_STATUS_OFS = 4'h4;
	localparam logic [3:0] ADP_CONFIG_OFS = 4'h8;

	// ==========================================================
	// control field positions and reset value
	localparam int         ADP_CTRL_A_MODE_LSB = 0;
	localparam int         ADP_CTRL_B_MODE_LSB = 2;
	localparam logic [1:0] ADP_MODE_RESET      = 2'h0;

	// ==========================================================
	// status field positions (write one to clear)
	localparam int ADP_ST_A_OOR_BIT = 0;
	localparam int ADP_ST_B_OOR_BIT = 1;

	// ==========================================================
	// config field positions (read only)
	localparam int ADP_CFG_OK_BIT    = 0;
	localparam int ADP_CFG_BYTEW_BIT = 1;

	// ==========================================================
	// architectural limits
	localparam int ADP_MAX_RATIO      = 32;
	localparam int ADP_MAX_BYTE_RATIO = 4;
	localparam int ADP_MAX_WIDTH      = 1152;

	typedef struct packed {
		adp_mode_t b_mode;
		adp_mode_t a_mode;
	} adp_ctrl_t;

	typedef struct packed {
		logic b_oor;
		logic a_oor;
	} adp_status_t;

endpackage : adp_pkg

// file: adp_store.sv
`timescale 1ns/1ps
module adp_store
	import adp_pkg::*;
#(
	parameter int W   = 64,
	parameter int DW  = 512,
	parameter int WAW = 9
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	// two ports, index 0 is port a
	input  wire logic             en_i    [2],
	input  wire logic [WAW-1:0]   addr_i  [2],
	input  wire logic [W-1:0]     mask_i  [2],
	input  wire logic [W-1:0]     wdata_i [2],
	input  wire adp_mode_t        mode_i  [2],
	output logic      [W-1:0]     rdata_o [2]
);

	logic [W-1:0] mem_q [DW];
	logic [W-1:0] rdata_q [2];

	// ==========================================================
	// shared array; port b is applied last on a same-word clash
	always_ff @(posedge clk_i) begin
		for (int p = 0; p < 2; p++) begin
			if (en_i[p] && (|mask_i[p])) begin
				mem_q[addr_i[p]] <= (mem_q[addr_i[p]] & ~mask_i[p])
					| (wdata_i[p] & mask_i[p]);
			end
		end
	end

	// ==========================================================
	// registered read word, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_q[0] <= '0;
			rdata_q[1] <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				if (en_i[p]) begin
					if (!(|mask_i[p])) begin
						rdata_q[p] <= mem_q[addr_i[p]];
					end else begin
						unique case (mode_i[p])
							adp_write_first: rdata_q[p] <= (mem_q[addr_i[p]] & ~mask_i[p])
								| (wdata_i[p] & mask_i[p]);
							adp_hold: rdata_q[p] <= rdata_q[p];
							default: rdata_q[p] <= mem_q[addr_i[p]];
						endcase
					end
				end
			end
		end
	end

	assign rdata_o = rdata_q;

endmodule : adp_store

// file: adp_ram.sv
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - port widths differ by power-of-two up to 32
// - narrow words packed little-endian into wide
// - read and write widths per port may differ
// - single port: write and read widths independent
// - any two buses within 32:1, max 1152
// - interface depth scales inversely with width
// - one address bus sized for deeper interface
// - shallower interface ignores low address bits
// - byte writes limit all ratios to 4:1
// - fixed primitive bounds widths 1:N to 32:N
// - eight-bit bytes: no parity, width multiple 8
// - nine-bit bytes: ninth bit parity, multiple 9
// - one strobe per write byte, msb to msb
// - only strobed bytes are updated
// - byte writes never combined with hold mode
// - write-first shows newly written data
// - write-first with byte or ratio undefined
// - two independent ports share one array
// - read-first shows old data during write
// - hold mode keeps previous read output
// - out-of-range writes leave array untouched
module adp_ram
	import adp_pkg::*;
#(
	parameter int A_WR_W     = 32,
	parameter int A_RD_W     = 32,
	parameter int B_WR_W     = 8,
	parameter int B_RD_W     = 8,
	parameter int A_WR_DEPTH = 2048,
	parameter bit BYTE_WRITE = 1'b0,
	parameter int BYTE_W     = 8,
	parameter int PRIM_W     = 0,
	parameter int SINGLE     = 0,
	// derived sizes, not meant to be overridden
	parameter int MEM_BITS   = A_WR_W * A_WR_DEPTH,
	parameter int A_MIN_W    = (A_WR_W < A_RD_W) ? A_WR_W : A_RD_W,
	parameter int B_MIN_W    = (B_WR_W < B_RD_W) ? B_WR_W : B_RD_W,
	parameter int A_LOC_W    = $clog2(MEM_BITS / A_MIN_W),
	parameter int B_LOC_W    = $clog2(MEM_BITS / B_MIN_W),
	parameter int A_STB_W    = BYTE_WRITE ? A_WR_W / BYTE_W : 1,
	parameter int B_STB_W    = BYTE_WRITE ? B_WR_W / BYTE_W : 1
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	// avalon-mm register slave
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	// port a
	input  wire logic                 port_a_enable_i,
	input  wire logic [A_LOC_W-1:0]   port_a_location_i,
	input  wire logic [A_STB_W-1:0]   port_a_byte_write_strobes_i,
	input  wire logic [A_WR_W-1:0]    port_a_write_data_i,
	output logic      [A_RD_W-1:0]    port_a_read_data_o,
	// port b
	input  wire logic                 port_b_enable_i,
	input  wire logic [B_LOC_W-1:0]   port_b_location_i,
	input  wire logic [B_STB_W-1:0]   port_b_byte_write_strobes_i,
	input  wire logic [B_WR_W-1:0]    port_b_write_data_i,
	output logic      [B_RD_W-1:0]    port_b_read_data_o,
	// configuration check
	output logic                      config_error_o
);

	// ==========================================================
	// configuration legality
	function automatic bit pow2_ratio(input int x, input int y, input int lim);
		int hi;
		int lo;
		hi = (x > y) ? x : y;
		lo = (x > y) ? y : x;
		return (lo > 0) && (hi % lo == 0) && ((hi / lo) <= lim)
			&& (((hi / lo) & ((hi / lo) - 1)) == 0);
	endfunction : pow2_ratio

	localparam int WIDTHS [4] = '{A_WR_W, A_RD_W, B_WR_W, B_RD_W};
	localparam int MAX_W_A = (A_WR_W > A_RD_W) ? A_WR_W : A_RD_W;
	localparam int MAX_W_B = (B_WR_W > B_RD_W) ? B_WR_W : B_RD_W;
	localparam int W       = (MAX_W_A > MAX_W_B) ? MAX_W_A : MAX_W_B;
	localparam int DW      = MEM_BITS / W;
	localparam int WAW     = (DW > 2) ? $clog2(DW) : 1;
	localparam int RATIO_LIM = BYTE_WRITE ? ADP_MAX_BYTE_RATIO : ADP_MAX_RATIO;

	function automatic bit cfg_check();
		bit ok;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			ok &= (WIDTHS[i] <= ADP_MAX_WIDTH);
			for (int j = 0; j < 4; j++) begin
				ok &= pow2_ratio(WIDTHS[i], WIDTHS[j], RATIO_LIM);
			end
			if (BYTE_WRITE) begin
				ok &= (WIDTHS[i] % BYTE_W == 0);
			end
			if (PRIM_W > 0) begin
				ok &= (WIDTHS[i] * PRIM_W >= A_WR_W)
					&& (WIDTHS[i] * PRIM_W <= ADP_MAX_RATIO * A_WR_W);
			end
		end
		ok &= (BYTE_W == 8) || (BYTE_W == 9);
		ok &= (MEM_BITS % W == 0);
		return ok;
	endfunction : cfg_check

	localparam bit CFG_OK = cfg_check();

	assign config_error_o = !CFG_OK;

	// ==========================================================
	// register file
	adp_ctrl_t   ctrl_q;
	adp_status_t status_q;
	adp_status_t oor_set;
	logic        ack_q;
	logic [31:0] rdata_q;
	logic        acc;
	logic        wr_ctrl;
	logic        wr_status;

	assign acc             = avs_read || avs_write;
	assign avs_waitrequest = acc && !ack_q;
	assign avs_readdata    = rdata_q;
	assign wr_ctrl   = avs_write && ack_q && (avs_address == ADP_CTRL_OFS) && avs_byteenable[0];
	assign wr_status = avs_write && ack_q && (avs_address == ADP_STATUS_OFS)
		&& avs_byteenable[0];

	// one wait state on every access; read data is latched in it
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= acc && !ack_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			rdata_q <= 32'h0000_0000;
			unique case (avs_address)
				ADP_CTRL_OFS: rdata_q[3:0] <= ctrl_q;
				ADP_STATUS_OFS: rdata_q[1:0] <= status_q;
				ADP_CONFIG_OFS: begin
					rdata_q[ADP_CFG_OK_BIT]    <= CFG_OK;
					rdata_q[ADP_CFG_BYTEW_BIT] <= BYTE_WRITE;
				end
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_q <= {ADP_MODE_RESET, ADP_MODE_RESET};
		end else if (wr_ctrl) begin
			ctrl_q.a_mode <= adp_mode_t'(avs_writedata[ADP_CTRL_A_MODE_LSB +: 2]);
			ctrl_q.b_mode <= adp_mode_t'(avs_writedata[ADP_CTRL_B_MODE_LSB +: 2]);
		end
	end

	// a new out-of-range event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			status_q <= '0;
		end else begin
			status_q.a_oor <= oor_set.a_oor
				|| (status_q.a_oor && !(wr_status && avs_writedata[ADP_ST_A_OOR_BIT]));
			status_q.b_oor <= oor_set.b_oor
				|| (status_q.b_oor && !(wr_status && avs_writedata[ADP_ST_B_OOR_BIT]));
		end
	end

	// ==========================================================
	// per-port address mapping and write masks
	localparam int WR_W [2] = '{A_WR_W, B_WR_W};
	localparam int RD_W [2] = '{A_RD_W, B_RD_W};
	localparam int MIN_W [2] = '{A_MIN_W, B_MIN_W};
	localparam int STB_W [2] = '{A_STB_W, B_STB_W};

	logic            en      [2];
	logic [31:0]     loc     [2];
	logic [W-1:0]    wdata_in[2];
	logic [31:0]     stb_in  [2];
	adp_mode_t       mode_reg[2];
	logic [WAW-1:0]  s_addr  [2];
	logic [W-1:0]    s_mask  [2];
	logic [W-1:0]    s_wdata [2];
	adp_mode_t       s_mode  [2];
	logic [W-1:0]    s_rdata [2];
	logic [31:0]     lane_q  [2];

	assign en[0]       = port_a_enable_i;
	assign en[1]       = port_b_enable_i;
	assign loc[0]      = 32'(port_a_location_i);
	assign loc[1]      = 32'(port_b_location_i);
	assign wdata_in[0] = W'(port_a_write_data_i);
	assign wdata_in[1] = W'(port_b_write_data_i);
	assign stb_in[0]   = 32'(port_a_byte_write_strobes_i);
	assign stb_in[1]   = 32'(port_b_byte_write_strobes_i);
	assign mode_reg[0] = ctrl_q.a_mode;
	assign mode_reg[1] = ctrl_q.b_mode;

	logic wr_ok_0;
	logic wr_ok_1;

	// one driver for the whole event word keeps both flags in step
	assign oor_set = '{b_oor: en[1] && (|stb_in[1]) && !wr_ok_1,
		a_oor: en[0] && (|stb_in[0]) && !wr_ok_0};

	for (genvar p = 0; p < 2; p++) begin : g_port
		localparam int WSH   = $clog2(WR_W[p] / MIN_W[p]);
		localparam int RSH   = $clog2(RD_W[p] / MIN_W[p]);
		localparam int WLN   = W / WR_W[p];
		localparam int RLN   = W / RD_W[p];
		localparam int WDEP  = MEM_BITS / WR_W[p];
		localparam int RDEP  = MEM_BITS / RD_W[p];
		localparam int WORDSH = $clog2(W / MIN_W[p]);
		logic [31:0]       w_idx;
		logic [31:0]       r_idx;
		logic [31:0]       w_lane;
		logic [WR_W[p]-1:0] bit_en;
		logic              wr_ok;
		logic              wr_any;
		adp_mode_t         mode_eff;

		assign w_idx  = loc[p] >> WSH;
		assign r_idx  = loc[p] >> RSH;
		assign w_lane = w_idx % WLN;
		assign wr_ok  = w_idx < WDEP;
		assign wr_any = |stb_in[p][STB_W[p]-1:0];

		// strobe k covers byte k, so the top strobe guards the top byte
		for (genvar b = 0; b < WR_W[p]; b++) begin : g_bit
			assign bit_en[b] = BYTE_WRITE ? stb_in[p][b / BYTE_W] : stb_in[p][0];
		end

		// hold output cannot be honoured across partial byte writes
		always_comb begin
			mode_eff = mode_reg[p];
			if (BYTE_WRITE && (mode_reg[p] == adp_hold)) begin
				mode_eff = adp_read_first;
			end
			if (!(mode_eff inside {adp_read_first, adp_write_first, adp_hold})) begin
				mode_eff = adp_read_first;
			end
		end

		assign s_addr[p]  = WAW'(loc[p] >> WORDSH);
		assign s_mask[p]  = (wr_ok && wr_any) ? (W'(bit_en) << (w_lane * WR_W[p])) : '0;
		assign s_wdata[p] = W'(wdata_in[p][WR_W[p]-1:0]) << (w_lane * WR_W[p]);
		assign s_mode[p]  = mode_eff;

		// the lane register follows the data word, so hold keeps both
		always_ff @(posedge clk_i) begin
			if (!resetn_i) begin
				lane_q[p] <= 32'h0000_0000;
			end else if (en[p] && !(wr_ok && wr_any && (mode_eff == adp_hold))) begin
				lane_q[p] <= (r_idx < RDEP) ? (r_idx % RLN) : 32'h0000_0000;
			end
		end

		if (p == 0) begin : g_ok0
			assign wr_ok_0 = wr_ok;
		end else begin : g_ok1
			assign wr_ok_1 = wr_ok;
		end
	end

	// ==========================================================
	// storage array
	adp_store #(
		.W   (W),
		.DW  (DW),
		.WAW (WAW)
	) u_store (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.en_i     (en),
		.addr_i   (s_addr),
		.mask_i   (s_mask),
		.wdata_i  (s_wdata),
		.mode_i   (s_mode),
		.rdata_o  (s_rdata)
	);

	// ==========================================================
	// lane select on the registered word
	assign port_a_read_data_o = A_RD_W'(s_rdata[0] >> (lane_q[0] * A_RD_W));
	assign port_b_read_data_o = B_RD_W'(s_rdata[1] >> (lane_q[1] * B_RD_W));

endmodule : adp_ram

// file: adp_ram_assertions.sv
`timescale 1ns/1ps
module adp_ram_assertions
	import adp_pkg::*;
#(
	parameter int A_WR_W     = 32,
	parameter int A_RD_W     = 32,
	parameter int B_RD_W     = 8,
	parameter int A_STB_W    = 1,
	parameter bit BYTE_WRITE = 1'b0
) (
	// clock and reset
	input wire logic               clk_i,
	input wire logic               resetn_i,
	// register bus
	input wire logic [3:0]         avs_address,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_writedata,
	input wire logic [3:0]         avs_byteenable,
	input wire logic [31:0]        avs_readdata,
	input wire logic               avs_waitrequest,
	// memory ports
	input wire logic               port_a_enable_i,
	input wire logic [A_STB_W-1:0] port_a_byte_write_strobes_i,
	input wire logic [A_WR_W-1:0]  port_a_write_data_i,
	input wire logic [A_RD_W-1:0]  port_a_read_data_o,
	input wire logic               port_b_enable_i,
	input wire logic [B_RD_W-1:0]  port_b_read_data_o,
	input wire logic               config_error_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// ==========================================================
	// shadow of the port a mode, taken where the bus write lands
	logic [1:0] a_mode_q;
	always_ff @(posedge clk_i) begin
		if (!resetn_i)
			a_mode_q <= 2'h0;
		else if (avs_write && !avs_waitrequest && avs_address == ADP_CTRL_OFS && avs_byteenable[0])
			a_mode_q <= avs_writedata[1:0];
	end

	// ==========================================================
	// properties
	property p_a_stands;
		!port_a_enable_i |=> $stable(port_a_read_data_o);
	endproperty
	a_a_stands: assert property (p_a_stands) else $error("port a output moved while idle");
	property p_b_stands;
		!port_b_enable_i |=> $stable(port_b_read_data_o);
	endproperty
	a_b_stands: assert property (p_b_stands) else $error("port b output moved while idle");
	property p_a_wfirst;
		port_a_enable_i && a_mode_q == 2'h1 && (&port_a_byte_write_strobes_i) && A_WR_W == A_RD_W
			|=> port_a_read_data_o == $past(port_a_write_data_i[A_RD_W-1:0]);
	endproperty
	a_a_wfirst: assert property (p_a_wfirst) else $error("write-first output wrong");
	property p_cfg_err;
		config_error_o == 1'b0;
	endproperty
	a_cfg_err: assert property (p_cfg_err) else $error("legal setup flagged");
	property p_cfg_rd;
		avs_read && !avs_waitrequest && avs_address == ADP_CONFIG_OFS
			|-> avs_readdata[1:0] == {BYTE_WRITE, 1'b1};
	endproperty
	a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
	property p_unmapped;
		avs_read && !avs_waitrequest && avs_address == 4'hc |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_wait_first;
		$rose(avs_read) || $rose(avs_write) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait state");
	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
endmodule : adp_ram_assertions

bind adp_ram adp_ram_assertions #(
	.A_WR_W(A_WR_W), .A_RD_W(A_RD_W), .B_RD_W(B_RD_W),
	.A_STB_W(A_STB_W), .BYTE_WRITE(BYTE_WRITE)
) u_adp_chk (
	.clk_i(clk_i), .resetn_i(resetn_i), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .port_a_enable_i(port_a_enable_i),
	.port_a_byte_write_strobes_i(port_a_byte_write_strobes_i),
	.port_a_write_data_i(port_a_write_data_i), .port_a_read_data_o(port_a_read_data_o),
	.port_b_enable_i(port_b_enable_i), .port_b_read_data_o(port_b_read_data_o),
	.config_error_o(config_error_o)
);

// file: adp_user.sv
`timescale 1ns/1ps
module adp_user #(
	parameter int LW = 6,
	parameter int SW = 4,
	// write and read words share one width on each port of this bench
	parameter int DW = 32
) (
	// clock
	input  wire logic          clk_i,
	// memory port
	output logic               en_o,
	output logic [LW-1:0]      loc_o,
	output logic [SW-1:0]      stb_o,
	output logic [DW-1:0]      wdata_o,
	input  wire logic [DW-1:0] rdata_i
);
	initial begin
		en_o = 1'b0;
		loc_o = '0;
		stb_o = '0;
		wdata_o = '0;
	end

	// ==========================================================
	// one access, result sampled once the taking edge has landed
	task automatic access(input logic [LW-1:0] loc, input logic [SW-1:0] stb,
		input logic [DW-1:0] wd, output logic [DW-1:0] rd);
		@(posedge clk_i);
		en_o <= 1'b1;
		loc_o <= loc;
		stb_o <= stb;
		wdata_o <= wd;
		@(posedge clk_i);
		en_o <= 1'b0;
		stb_o <= '0;
		// idle lines toggle so a stale value cannot pass for a result
		wdata_o <= ~wd;
		loc_o <= ~loc;
		@(negedge clk_i);
		rd = rdata_i;
	endtask : access
endmodule : adp_user

// file: test_adp_ram.sv
`timescale 1ns/1ps
module test_adp_ram
	import adp_pkg::*;
;
	logic        clk_i, resetn_i, avs_read, avs_write, avs_waitrequest, cfg_err;
	logic [3:0]  avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic        a_en, b_en, b_stb;
	logic [5:0]  a_loc;
	logic [7:0]  b_loc, b_wd, b_rd, rb;
	logic [3:0]  a_stb;
	logic [31:0] a_wd, a_rd;
	int          fail_count, samples_checked;

	adp_ram #(.A_WR_DEPTH(48), .BYTE_WRITE(1'b1)) dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .port_a_enable_i(a_en), .port_a_location_i(a_loc),
		.port_a_byte_write_strobes_i(a_stb), .port_a_write_data_i(a_wd),
		.port_a_read_data_o(a_rd), .port_b_enable_i(b_en), .port_b_location_i(b_loc),
		.port_b_byte_write_strobes_i(b_stb), .port_b_write_data_i(b_wd),
		.port_b_read_data_o(b_rd), .config_error_o(cfg_err));
	adp_user ua (.clk_i(clk_i), .en_o(a_en),
		.loc_o(a_loc), .stb_o(a_stb), .wdata_o(a_wd), .rdata_i(a_rd));
	adp_user #(.LW(8), .SW(1), .DW(8)) ub (.clk_i(clk_i), .en_o(b_en),
		.loc_o(b_loc), .stb_o(b_stb), .wdata_o(b_wd), .rdata_i(b_rd));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ==========================================================
	// common tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
			fail_count++;
		end
	endtask : check
	task automatic avm(input bit wr, input logic [3:0] adr, input logic [31:0] wd,
		output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		avs_address <= adr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 20) check(1'b1, 1'b0, "bus wait timeout");
	endtask : avm
	task automatic summarize();
		$display("checked %0d failed %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize

	// ==========================================================
	// scenarios
	task automatic t_regs();
		avm(1'b0, ADP_CONFIG_OFS, 32'h0, r);
		check(r & 32'h3, 32'h3, "config");
		check({31'h0, cfg_err}, 32'h0, "config error");
		avm(1'b0, ADP_CTRL_OFS, 32'h0, r);
		check(r, 32'h0, "ctrl reset");
		avs_byteenable <= 4'h0;
		avm(1'b1, ADP_CTRL_OFS, 32'h1, r);
		avs_byteenable <= 4'h1;
		avm(1'b0, ADP_CTRL_OFS, 32'h0, r);
		check(r, 32'h0, "byteenable off ignored");
		avm(1'b0, 4'hc, 32'h0, r);
		check(r, 32'h0, "unmapped");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_pack();
		ua.access(6'd3, 4'hf, 32'h44332211, r);
		for (int i = 0; i < 4; i++) begin
			ub.access(8'(12 + i), 1'b0, 8'h0, rb);
			check({24'h0, rb}, (32'h44332211 >> (8 * i)) & 32'hff, "b lane");
		end
		for (int i = 0; i < 4; i++)
			ub.access(8'(20 + i), 1'b1, 8'(16 * i + 5), rb);
		ua.access(6'd5, 4'h0, 32'h0, r);
		check(r, 32'h35251505, "a packed");
		$display("t_pack done");
	endtask : t_pack
	task automatic t_bytes();
		ua.access(6'd1, 4'hf, 32'h0, r);
		ua.access(6'd1, 4'b0101, 32'hddccbbaa, r);
		ua.access(6'd1, 4'h0, 32'h0, r);
		check(r, 32'h00cc00aa, "byte strobes");
		ua.access(6'd1, 4'b1000, 32'heeffffff, r);
		ua.access(6'd1, 4'h0, 32'h0, r);
		check(r, 32'heecc00aa, "top strobe");
		$display("t_bytes done");
	endtask : t_bytes
	task automatic t_modes();
		ua.access(6'd7, 4'hf, 32'h11111111, r);
		ua.access(6'd7, 4'hf, 32'h22222222, r);
		check(r, 32'h11111111, "read-first");
		avm(1'b1, ADP_CTRL_OFS, 32'h1, r);
		ua.access(6'd7, 4'hf, 32'h33333333, r);
		check(r, 32'h33333333, "write-first");
		avm(1'b1, ADP_CTRL_OFS, 32'h2, r);
		avm(1'b0, ADP_CTRL_OFS, 32'h0, r);
		check(r, 32'h2, "ctrl readback");
		ua.access(6'd3, 4'h0, 32'h0, r);
		ua.access(6'd7, 4'hf, 32'h44444444, r);
		check(r, 32'h33333333, "hold with strobes");
		avm(1'b1, ADP_CTRL_OFS, 32'h3, r);
		avm(1'b0, ADP_CTRL_OFS, 32'h0, r);
		check(r, 32'h3, "ctrl code three");
		ua.access(6'd7, 4'hf, 32'h55555555, r);
		check(r, 32'h44444444, "code three read-first");
		avm(1'b1, ADP_CTRL_OFS, 32'h0, r);
		$display("t_modes done");
	endtask : t_modes
	task automatic t_oor();
		ua.access(6'd2, 4'hf, 32'h12345678, r);
		ua.access(6'd50, 4'hf, 32'hdeadbeef, r);
		avm(1'b0, ADP_STATUS_OFS, 32'h0, r);
		check(r & 32'h3, 32'h1, "oor flag");
		ua.access(6'd2, 4'h0, 32'h0, r);
		check(r, 32'h12345678, "no wrap");
		avm(1'b1, ADP_STATUS_OFS, 32'h1, r);
		avm(1'b0, ADP_STATUS_OFS, 32'h0, r);
		check(r & 32'h3, 32'h0, "flag cleared");
		ub.access(8'd200, 1'b1, 8'h5a, rb);
		avm(1'b0, ADP_STATUS_OFS, 32'h0, r);
		check(r & 32'h3, 32'h2, "b oor flag");
		avm(1'b1, ADP_STATUS_OFS, 32'h2, r);
		avm(1'b0, ADP_STATUS_OFS, 32'h0, r);
		check(r & 32'h3, 32'h0, "b flag cleared");
		$display("t_oor done");
	endtask : t_oor

	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		summarize();
	end

	initial begin
		resetn_i = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h1;
		repeat (10) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_pack();
		t_bytes();
		t_modes();
		t_oor();
		summarize();
	end
endmodule : test_adp_ram
